// file: rtl/pmt_timer.sv
// Period-match 8-bit timer with prescaler, postscaler, interrupt and register port
`timescale 1ns/10ps
`include "pmt_cfg.svh"

// Summary of operation
// - While on, count rises from zero once per prescaled instruction tick.
// - Four-bit prescaler divides by 1, 4 or 16 per select bits 1-0.
// - Count is compared with period; equality gives the match output.
// - After a match the count restarts at zero and the postscaler advances.
// - Reset clears the count and sets the period to FFh.
// - Count write, control write or reset clears prescaler and postscaler.
// - A control write leaves the count value unchanged.
// - Count and period are readable and writable at any time.
// - Postscaler divides matches by 1 to 16 per select bits 6-3.
// - Postscaler terminal count sets the sticky match flag, bit 1.
// - Interrupt is raised only when the match enable bit 1 is set.
// - Control bit 2 runs the timer when one, stops it when zero.
// - Control bit 7 is unimplemented and reads as zero.
// - Unscaled match pulse is offered as the PWM time base.
// - Timer output is offered as a serial shift clock source.
module pmt_timer #(
    parameter int unsigned INST_DIV = `PMT_INST_DIV
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire pmt_pkg::pmt_addr_t addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic irq_o,
    output logic match_o,
    output logic shift_clk_o
);
    import pmt_pkg::*;

    // INST_DIV must be at least 2
    localparam int unsigned PH_W = $clog2(INST_DIV);
    localparam logic [PH_W-1:0] PH_END = PH_W'(INST_DIV - 1);

    // Terminal count of the prescaler for a select code
    function automatic logic [3:0] presc_end(input logic [1:0] sel);
        logic [3:0] r;
        r = `PMT_PRESC_END_16;
        unique case (sel)
            2'h0: r = `PMT_PRESC_END_1;
            2'h1: r = `PMT_PRESC_END_4;
            default: r = `PMT_PRESC_END_16;
        endcase
        return r;
    endfunction : presc_end

    logic [PH_W-1:0] phase_q;
    logic [3:0] presc_q;
    logic [3:0] postsc_q;
    logic [7:0] count_q;
    logic [7:0] period_q;
    pmt_ctrl_t ctrl_q;
    logic flag_q;
    logic enable_q;
    logic [7:0] rdata_q;
    logic irq_q;
    logic match_q;
    logic shift_q;

    logic wr_count;
    logic wr_period;
    logic wr_ctrl;
    logic wr_enables;
    logic rd_flags;
    logic scaler_clr;
    logic inst_tick;
    logic count_tick;
    logic hit;
    logic post_hit;
    logic [7:0] rd_mux;

    assign wr_count = wr_i && (addr_i == `PMT_OFF_COUNT);
    assign wr_period = wr_i && (addr_i == `PMT_OFF_PERIOD);
    assign wr_ctrl = wr_i && (addr_i == `PMT_OFF_CTRL);
    assign wr_enables = wr_i && (addr_i == `PMT_OFF_ENABLES);
    assign rd_flags = rd_i && (addr_i == `PMT_OFF_FLAGS);

    // Count and control writes take priority over counting in the same cycle
    assign scaler_clr = wr_count || wr_ctrl;

    // Instruction clock is the core clock divided by INST_DIV
    assign inst_tick = (phase_q == PH_END);

    assign count_tick = ctrl_q.timer_on && inst_tick && !scaler_clr
        && (presc_q == presc_end(ctrl_q.prescale_select));

    assign hit = count_tick && (count_q == period_q);

    assign post_hit = hit && (postsc_q == ctrl_q.postscale_select);

    // Instruction phase runs free; it is the device clock, not the timer
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase_q <= '0;
        end else if (inst_tick) begin
            phase_q <= '0;
        end else begin
            phase_q <= PH_W'(phase_q + 1'b1);
        end
    end

    // Prescaler
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            presc_q <= 4'h0;
        end else if (scaler_clr) begin
            presc_q <= 4'h0;
        end else if (ctrl_q.timer_on && inst_tick) begin
            if (presc_q == presc_end(ctrl_q.prescale_select)) begin
                presc_q <= 4'h0;
            end else begin
                presc_q <= 4'(presc_q + 4'h1);
            end
        end
    end

    // Count register
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_q <= `PMT_RST_COUNT;
        end else if (wr_count) begin
            count_q <= wdata_i;
        end else if (hit) begin
            count_q <= 8'h00;
        end else if (count_tick) begin
            count_q <= 8'(count_q + 8'h01);
        end
    end

    // Period register
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            period_q <= `PMT_RST_PERIOD;
        end else if (wr_period) begin
            period_q <= wdata_i;
        end
    end

    // Control register; bit 7 is never stored
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_q <= `PMT_RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_q <= {1'b0, wdata_i[6:0]};
        end
    end

    // Postscaler
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            postsc_q <= 4'h0;
        end else if (scaler_clr) begin
            postsc_q <= 4'h0;
        end else if (post_hit) begin
            postsc_q <= 4'h0;
        end else if (hit) begin
            postsc_q <= 4'(postsc_q + 4'h1);
        end
    end

    // Sticky flag; a postscaler terminal count in the cycle of a clearing read still sets it
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flag_q <= 1'b0;
        end else if (post_hit) begin
            flag_q <= 1'b1;
        end else if (rd_flags) begin
            flag_q <= 1'b0;
        end
    end

    // Interrupt enable
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            enable_q <= 1'b0;
        end else if (wr_enables) begin
            enable_q <= wdata_i[`PMT_ENABLE_BIT];
        end
    end

    // Interrupt output, one cycle behind the flag
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= flag_q && enable_q;
        end
    end

    // Match pulse and shift clock outputs
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            match_q <= 1'b0;
        end else begin
            match_q <= hit;
        end
    end

    // Shift clock toggles per match, so it runs at half the match rate
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shift_q <= 1'b0;
        end else if (hit) begin
            shift_q <= !shift_q;
        end
    end

    // Read multiplexer; unmapped offsets read as zero
    always_comb begin
        rd_mux = 8'h00;
        unique case (addr_i)
            `PMT_OFF_COUNT: rd_mux = count_q;
            `PMT_OFF_PERIOD: rd_mux = period_q;
            `PMT_OFF_CTRL: rd_mux = {1'b0, ctrl_q[6:0]};
            `PMT_OFF_FLAGS: rd_mux[`PMT_FLAG_BIT] = flag_q;
            `PMT_OFF_ENABLES: rd_mux[`PMT_ENABLE_BIT] = enable_q;
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data stands for exactly one cycle after the strobe
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q <= 8'h00;
        end else if (rd_i) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o = irq_q;
    assign match_o = match_q;
    assign shift_clk_o = shift_q;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_ctrl_write;
        wr_ctrl;
    endsequence

    sequence s_scalers_clear;
        presc_q == 4'h0 && postsc_q == 4'h0;
    endsequence

    sequence s_wrap;
        count_tick && count_q == period_q;
    endsequence

    sequence s_restart;
        count_q == 8'h00 && match_o;
    endsequence

    sequence s_irq_armed;
        flag_q && enable_q;
    endsequence

    a_count_wrap: assert property (s_wrap |=> s_restart)
        else $error("count did not restart with a match pulse");

    a_count_step: assert property (
        count_tick && count_q != period_q |=> count_q == 8'($past(count_q) + 8'h01)
    )
        else $error("count did not step by one on a tick");

    a_off_hold: assert property (
        !ctrl_q.timer_on && !wr_i |=> $stable(count_q) && $stable(presc_q) && !match_o
    )
        else $error("timer moved while switched off");

    // A drifting postscaler would shorten the first interrupt after a restart
    a_off_post: assert property (
        !ctrl_q.timer_on && !wr_i |=> $stable(postsc_q)
    )
        else $error("postscaler moved while switched off");

    a_ctrl_keeps: assert property (
        s_ctrl_write |=> s_scalers_clear and $stable(count_q)
    )
        else $error("control write disturbed the count or scalers");

    a_ctrl_load: assert property (
        wr_ctrl |=> ctrl_q == {1'b0, $past(wdata_i[6:0])}
    )
        else $error("control write did not load");

    a_count_write: assert property (
        wr_count |=> count_q == $past(wdata_i) && presc_q == 4'h0 && postsc_q == 4'h0
    )
        else $error("count write did not load and clear scalers");

    a_period_load: assert property (
        wr_period |=> period_q == $past(wdata_i)
    )
        else $error("period write did not load");

    a_flag_set: assert property (post_hit |=> flag_q)
        else $error("postscaler terminal count missed the flag");

    // A clearing read loses to a terminal count in the same cycle
    a_flag_clear: assert property (
        rd_flags && !post_hit |=> !flag_q
    )
        else $error("flag survived its clearing read");

    a_flag_hold: assert property (
        flag_q && !rd_flags |=> flag_q
    )
        else $error("flag dropped without a read");

    a_enable_load: assert property (
        wr_enables |=> enable_q == $past(wdata_i[`PMT_ENABLE_BIT])
    )
        else $error("enable write did not load");

    a_irq_raise: assert property (s_irq_armed |=> irq_o)
        else $error("enabled flag raised no interrupt");

    a_irq_drop: assert property (!(flag_q && enable_q) |=> !irq_o)
        else $error("interrupt without an enabled flag");

    a_bit7_zero: assert property (
        rd_i && addr_i == `PMT_OFF_CTRL |=> rdata_o[7] == 1'b0
    )
        else $error("control bit 7 read as one");

    a_period_read: assert property (
        rd_i && addr_i == `PMT_OFF_PERIOD && !wr_i |=> rdata_o == $past(period_q)
    )
        else $error("period read returned a wrong value");

    a_read_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data stood without a read");

    a_post_step: assert property (
        hit && !post_hit |=> postsc_q == 4'($past(postsc_q) + 4'h1)
    )
        else $error("postscaler did not advance on a match");

    a_post_wrap: assert property (post_hit |=> postsc_q == 4'h0)
        else $error("postscaler did not wrap at its terminal count");

    a_match_cause: assert property (
        match_o |-> $past(count_tick) && $past(count_q) == $past(period_q)
            && count_q == 8'h00
    )
        else $error("match pulse without an equal compare");

    a_match_once: assert property (match_o |=> !match_o)
        else $error("match pulse wider than one cycle");

    a_match_on: assert property (match_o |-> $past(ctrl_q.timer_on))
        else $error("match pulse while the timer was off");

    a_shift_toggle: assert property (match_o |-> shift_clk_o != $past(shift_clk_o))
        else $error("shift clock did not toggle on a match");

    // The prescaler moves once per instruction tick, so its previous state lies one tick back
    a_presc_div16: assert property (
        count_tick && ctrl_q.prescale_select[1] |-> presc_q == `PMT_PRESC_END_16
            && $past(presc_q, INST_DIV) == 4'hE
    )
        else $error("divide-by-16 tick at wrong prescaler state");

    a_presc_div4: assert property (
        count_tick && ctrl_q.prescale_select == 2'h1 |-> presc_q == `PMT_PRESC_END_4
            && $past(presc_q, INST_DIV) == 4'h2
    )
        else $error("divide-by-4 tick at wrong prescaler state");

endmodule : pmt_timer

// file: rtl/pmt_cfg.svh
// Offsets, field positions, reset values and timing counts of the period-match timer
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH

// Register word offsets on the register port
`define PMT_OFF_COUNT 3'h0
`define PMT_OFF_PERIOD 3'h1
`define PMT_OFF_CTRL 3'h2
`define PMT_OFF_FLAGS 3'h3
`define PMT_OFF_ENABLES 3'h4

// Field positions
`define PMT_PRESC_LSB 0
`define PMT_ON_BIT 2
`define PMT_POSTSC_LSB 3
`define PMT_FLAG_BIT 1
`define PMT_ENABLE_BIT 1

// Reset values
`define PMT_RST_COUNT 8'h00
`define PMT_RST_PERIOD 8'hFF
`define PMT_RST_CTRL 8'h00

// Core clock cycles per instruction cycle
`define PMT_INST_DIV 4

// Prescaler terminal counts
`define PMT_PRESC_END_1 4'h0
`define PMT_PRESC_END_4 4'h3
`define PMT_PRESC_END_16 4'hF

`endif

// file: rtl/pmt_pkg.sv
// Types shared by the period-match timer
package pmt_pkg;

    typedef logic [2:0] pmt_addr_t;

    // Layout of the timer control register
    typedef struct packed {
        logic unused;
        logic [3:0] postscale_select;
        logic timer_on;
        logic [1:0] prescale_select;
    } pmt_ctrl_t;

endpackage : pmt_pkg

// file: test/tb_top.sv
// Self-checking register-level bench for the period-match timer
`timescale 1ns/10ps
`include "pmt_cfg.svh"
module tb_top;
    import pmt_pkg::*;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    pmt_addr_t addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic irq_o;
    logic match_o;
    logic shift_clk_o;
    int n_mismatch = 0;
    int checks = 0;
    logic [7:0] v;
    logic sh;
    int n;
    pmt_ctrl_t ctl;
    logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h5, 4'hF};

    pmt_timer uut (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .irq_o(irq_o),
        .match_o(match_o),
        .shift_clk_o(shift_clk_o)
    );

    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic final_report;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk8

    task automatic chk_cnt(input int got, input int exp, input string what);
        checks++;
        if (got != exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %0d want %0d", $time, what, got, exp);
        end
    endtask : chk_cnt

    task automatic timeout(input string what);
        n_mismatch++;
        $display("mismatch at %0t: timeout on %s", $time, what);
        final_report();
    endtask : timeout

    task automatic reg_wr(input pmt_addr_t a, input logic [7:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask : reg_wr

    // Read data is valid only in the cycle after the strobe, so sample it there
    task automatic reg_rd(input pmt_addr_t a, output logic [7:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : reg_rd

    task automatic wait_match(output int cyc);
        cyc = 0;
        do begin
            @(posedge core_clk_i);
            #1;
            cyc++;
            if (cyc > 2000) begin
                timeout("match");
            end
        end while (match_o !== 1'b1);
    endtask : wait_match

    initial begin
        repeat (4) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        reg_rd(`PMT_OFF_COUNT, v);
        chk8(v, 8'h00, "count reset");
        reg_rd(`PMT_OFF_PERIOD, v);
        chk8(v, 8'hFF, "period reset");
        reg_rd(`PMT_OFF_CTRL, v);
        chk8(v, 8'h00, "ctrl reset");
        reg_wr(`PMT_OFF_CTRL, 8'hFF);
        reg_rd(`PMT_OFF_CTRL, v);
        chk8(v, 8'h7F, "ctrl bit 7");
        reg_wr(`PMT_OFF_COUNT, 8'h37);
        reg_wr(`PMT_OFF_CTRL, 8'h00);
        reg_rd(`PMT_OFF_COUNT, v);
        chk8(v, 8'h37, "count after ctrl write");
        reg_wr(`PMT_OFF_PERIOD, 8'hA5);
        reg_rd(`PMT_OFF_PERIOD, v);
        chk8(v, 8'hA5, "period rw");
        reg_wr(3'h5, 8'hAA);
        reg_rd(3'h5, v);
        chk8(v, 8'h00, "unmapped");
        reg_wr(`PMT_OFF_FLAGS, 8'hFF);
        reg_rd(`PMT_OFF_FLAGS, v);
        chk8(v, 8'h00, "flags write");
        // Match spacing for every prescale code, 16x covered by both 10 and 11
        reg_wr(`PMT_OFF_PERIOD, 8'h03);
        for (int s = 0; s < 4; s++) begin
            ctl = '0;
            ctl.timer_on = 1'b1;
            ctl.prescale_select = s[1:0];
            reg_wr(`PMT_OFF_COUNT, 8'h00);
            reg_wr(`PMT_OFF_CTRL, ctl);
            wait_match(n);
            sh = shift_clk_o;
            wait_match(n);
            chk_cnt(n, 4 * (s == 0 ? 1 : (s == 1 ? 4 : 16)) * `PMT_INST_DIV, "gap");
            chk8({7'h00, shift_clk_o}, {7'h00, ~sh}, "shift clk");
            if (s != 0) begin
                reg_rd(`PMT_OFF_COUNT, v);
                chk8(v, 8'h00, "count after match");
            end
        end
        // Postscaler ratios and the interrupt path
        reg_wr(`PMT_OFF_PERIOD, 8'h00);
        reg_wr(`PMT_OFF_ENABLES, 8'h02);
        reg_wr(`PMT_OFF_CTRL, 8'h00);
        reg_rd(`PMT_OFF_FLAGS, v);
        foreach (codes[i]) begin
            ctl = '0;
            ctl.timer_on = 1'b1;
            ctl.postscale_select = codes[i];
            reg_wr(`PMT_OFF_COUNT, 8'h00);
            reg_wr(`PMT_OFF_CTRL, ctl);
            n = 0;
            for (int k = 0; k < 200 && irq_o !== 1'b1; k++) begin
                @(posedge core_clk_i);
                #1;
                if (match_o === 1'b1) begin
                    n++;
                end
            end
            if (irq_o !== 1'b1) begin
                timeout("irq");
            end
            chk_cnt(n, int'(codes[i]) + 1, "matches per flag");
            reg_wr(`PMT_OFF_CTRL, 8'h00);
            reg_rd(`PMT_OFF_FLAGS, v);
            chk8(v, 8'h02, "flag set");
            reg_rd(`PMT_OFF_FLAGS, v);
            chk8(v, 8'h00, "flag cleared");
            @(posedge core_clk_i);
            #1;
            chk8({7'h00, irq_o}, 8'h00, "irq after clear");
        end
        // Masked source: flag still latches, no request
        reg_wr(`PMT_OFF_ENABLES, 8'h00);
        reg_wr(`PMT_OFF_CTRL, 8'h04);
        repeat (20) @(posedge core_clk_i);
        #1;
        chk8({7'h00, irq_o}, 8'h00, "masked irq");
        reg_wr(`PMT_OFF_CTRL, 8'h00);
        reg_rd(`PMT_OFF_FLAGS, v);
        chk8(v, 8'h02, "masked flag");
        // Stopped timer holds its count and stays silent
        reg_wr(`PMT_OFF_COUNT, 8'h10);
        n = 0;
        repeat (100) begin
            @(posedge core_clk_i);
            #1;
            if (match_o === 1'b1) begin
                n++;
            end
        end
        chk_cnt(n, 0, "match while off");
        reg_rd(`PMT_OFF_COUNT, v);
        chk8(v, 8'h10, "count while off");
        // Count write part way through a divide-by-16 cycle restarts the prescaler
        reg_wr(`PMT_OFF_PERIOD, 8'hFF);
        reg_wr(`PMT_OFF_CTRL, 8'h06);
        repeat (40) @(posedge core_clk_i);
        reg_wr(`PMT_OFF_COUNT, 8'h05);
        repeat (40) @(posedge core_clk_i);
        reg_rd(`PMT_OFF_COUNT, v);
        chk8(v, 8'h05, "prescaler clear");
        // Second reset in mid-run
        reg_wr(`PMT_OFF_PERIOD, 8'h5A);
        @(posedge core_clk_i);
        resetn_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        reg_rd(`PMT_OFF_PERIOD, v);
        chk8(v, 8'hFF, "period rereset");
        reg_rd(`PMT_OFF_CTRL, v);
        chk8(v, 8'h00, "ctrl rereset");
        final_report();
    end
endmodule : tb_top
